// ===== core/pdm_pkg.sv
// Purpose: constants for the pseudo-random pulse density modulator
// Assumes: one component clock, plain register port
// Notes:
`default_nettype none

package pdm_pkg;

  localparam int unsigned LFSR_W = 8;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_SEED = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_SHADOW = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_TAPS = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_THR_A = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_THR_B = 3'h5;

  localparam int unsigned CTRL_W = 3;
  localparam int unsigned BIT_RUN = 0;
  localparam int unsigned BIT_CMP_A = 1;
  localparam int unsigned BIT_CMP_B = 2;

  // compare select encoding: 0 is less-or-equal, 1 is greater-or-equal
  localparam logic CMP_LE = 1'b0;
  localparam logic CMP_GE = 1'b1;

  localparam logic FIXED_COMPARE_OPTION = 1'b0;
  localparam logic FIXED_CMP_A = CMP_LE;
  localparam logic FIXED_CMP_B = CMP_LE;

  localparam logic [CTRL_W-1:0] RST_CTRL = 3'h0;
  localparam logic [LFSR_W-1:0] RST_SEED = 8'h01;
  localparam logic [LFSR_W-1:0] RST_TAPS = 8'hb8;
  localparam logic [LFSR_W-1:0] RST_THR_A = 8'h80;
  localparam logic [LFSR_W-1:0] RST_THR_B = 8'h80;

endpackage : pdm_pkg

`default_nettype wire

// ===== core/lfsr_pulse_density_modulator.sv
// Purpose: pseudo-random pulse density modulator with two density outputs
// Assumes: enable, reset and kill arrive from outside this clock domain
// Notes: register read data appear the cycle after the read strobe
`default_nettype none

module lfsr_pulse_density_modulator (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic [pdm_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [pdm_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [pdm_pkg::DATA_W-1:0] O_RDATA,
  input wire logic I_ENABLE,
  input wire logic I_RESET,
  input wire logic I_KILL,
  output logic O_DENSITY_OUT_A,
  output logic O_DENSITY_OUT_B,
  output logic O_BITSTREAM
);

  // input synchronisers: bit 0 enable, bit 1 reset, bit 2 kill
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic en_s;
  logic rst_s;
  logic kill_s;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {I_KILL, I_RESET, I_ENABLE};
      sync2_q <= sync1_q;
    end
  end

  assign en_s = sync2_q[0];
  assign rst_s = sync2_q[1];
  assign kill_s = sync2_q[2];

  // register file state
  logic [pdm_pkg::CTRL_W-1:0] ctrl_q;
  logic [pdm_pkg::CTRL_W-1:0] ctrl_d;
  logic [pdm_pkg::LFSR_W-1:0] seed_q;
  logic [pdm_pkg::LFSR_W-1:0] seed_d;
  logic [pdm_pkg::LFSR_W-1:0] shadow_q;
  logic [pdm_pkg::LFSR_W-1:0] shadow_d;
  logic [pdm_pkg::LFSR_W-1:0] taps_q;
  logic [pdm_pkg::LFSR_W-1:0] taps_d;
  logic [pdm_pkg::LFSR_W-1:0] thr_a_q;
  logic [pdm_pkg::LFSR_W-1:0] thr_a_d;
  logic [pdm_pkg::LFSR_W-1:0] thr_b_q;
  logic [pdm_pkg::LFSR_W-1:0] thr_b_d;
  logic [pdm_pkg::DATA_W-1:0] rdata_q;
  logic [pdm_pkg::DATA_W-1:0] rdata_d;

  logic [pdm_pkg::LFSR_W-1:0] wval;
  logic run_en;
  logic sel_a;
  logic sel_b;
  logic [pdm_pkg::LFSR_W-1:0] step_val;
  logic wr_seed;

  assign wval = I_WDATA[pdm_pkg::LFSR_W-1:0];
  assign wr_seed = I_WR && (I_ADDR == pdm_pkg::OFS_SEED);

  // with the fixed compare option there is no control register at all
  always_comb begin
    if (pdm_pkg::FIXED_COMPARE_OPTION) begin
      run_en = 1'b1;
      sel_a = pdm_pkg::FIXED_CMP_A;
      sel_b = pdm_pkg::FIXED_CMP_B;
    end else begin
      run_en = ctrl_q[pdm_pkg::BIT_RUN];
      sel_a = ctrl_q[pdm_pkg::BIT_CMP_A];
      sel_b = ctrl_q[pdm_pkg::BIT_CMP_B];
    end
  end

  // galois step: shift right, fold taps in when the leaving bit is one
  always_comb begin
    step_val = seed_q >> 1;
    if (seed_q[0]) begin
      step_val = (seed_q >> 1) ^ taps_q;
    end
  end

  // next values of the register file and the running number
  always_comb begin
    ctrl_d = ctrl_q;
    seed_d = seed_q;
    shadow_d = shadow_q;
    taps_d = taps_q;
    thr_a_d = thr_a_q;
    thr_b_d = thr_b_q;
    // reset input is only honoured once started, and beats enable
    if (run_en && rst_s) begin
      seed_d = shadow_q;
    end else if (run_en && en_s) begin
      seed_d = step_val;
    end
    // a software write to the seed lands last and so overrides the sequence step
    if (I_WR) begin
      unique case (I_ADDR)
        pdm_pkg::OFS_CTRL: begin
          if (!pdm_pkg::FIXED_COMPARE_OPTION) begin
            ctrl_d = I_WDATA[pdm_pkg::CTRL_W-1:0];
          end
        end
        pdm_pkg::OFS_SEED: begin
          seed_d = wval;
          shadow_d = wval;
        end
        pdm_pkg::OFS_SHADOW: begin
          shadow_d = wval;
        end
        pdm_pkg::OFS_TAPS: begin
          taps_d = wval;
        end
        pdm_pkg::OFS_THR_A: begin
          thr_a_d = wval;
        end
        pdm_pkg::OFS_THR_B: begin
          thr_b_d = wval;
        end
        default: begin
        end
      endcase
    end
  end

  // read mux; narrow fields sit in the low bits, unmapped reads give zero
  always_comb begin
    rdata_d = '0;
    if (I_RD) begin
      unique case (I_ADDR)
        pdm_pkg::OFS_CTRL: begin
          if (!pdm_pkg::FIXED_COMPARE_OPTION) begin
            rdata_d = pdm_pkg::DATA_W'(ctrl_q);
          end
        end
        pdm_pkg::OFS_SEED: begin
          rdata_d = pdm_pkg::DATA_W'(seed_q);
        end
        pdm_pkg::OFS_SHADOW: begin
          rdata_d = pdm_pkg::DATA_W'(shadow_q);
        end
        pdm_pkg::OFS_TAPS: begin
          rdata_d = pdm_pkg::DATA_W'(taps_q);
        end
        pdm_pkg::OFS_THR_A: begin
          rdata_d = pdm_pkg::DATA_W'(thr_a_q);
        end
        pdm_pkg::OFS_THR_B: begin
          rdata_d = pdm_pkg::DATA_W'(thr_b_q);
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ctrl_q <= pdm_pkg::RST_CTRL;
      seed_q <= pdm_pkg::RST_SEED;
      shadow_q <= pdm_pkg::RST_SEED;
      taps_q <= pdm_pkg::RST_TAPS;
      thr_a_q <= pdm_pkg::RST_THR_A;
      thr_b_q <= pdm_pkg::RST_THR_B;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      seed_q <= seed_d;
      shadow_q <= shadow_d;
      taps_q <= taps_d;
      thr_a_q <= thr_a_d;
      thr_b_q <= thr_b_d;
      rdata_q <= rdata_d;
    end
  end

  assign O_RDATA = rdata_q;

  // density outputs: one shared number, two thresholds, registered
  logic cmp_a;
  logic cmp_b;
  logic den_a_q;
  logic den_a_d;
  logic den_b_q;
  logic den_b_d;

  always_comb begin
    if (sel_a == pdm_pkg::CMP_GE) begin
      cmp_a = seed_q >= thr_a_q;
    end else begin
      cmp_a = seed_q <= thr_a_q;
    end
    if (sel_b == pdm_pkg::CMP_GE) begin
      cmp_b = seed_q >= thr_b_q;
    end else begin
      cmp_b = seed_q <= thr_b_q;
    end
  end

  always_comb begin
    den_a_d = den_a_q;
    den_b_d = den_b_q;
    if (kill_s) begin
      den_a_d = 1'b0;
      den_b_d = 1'b0;
    end else if (run_en) begin
      den_a_d = cmp_a;
      den_b_d = cmp_b;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      den_a_q <= 1'b0;
      den_b_q <= 1'b0;
    end else begin
      den_a_q <= den_a_d;
      den_b_q <= den_b_d;
    end
  end

  assign O_DENSITY_OUT_A = den_a_q;
  assign O_DENSITY_OUT_B = den_b_q;
  assign O_BITSTREAM = seed_q[0];

  // checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);

  sequence seed_write_s;
    wr_seed;
  endsequence

  sequence quiet_s;
    !I_WR;
  endsequence

  sequence restart_s;
    run_en && rst_s && !I_WR;
  endsequence

  chk_run_step: assert property (
    run_en && en_s && !rst_s && !I_WR |=> seed_q == $past(step_val))
    else $error("sequence did not advance by one galois step");

  chk_idle_hold: assert property (
    (!run_en || (!en_s && !rst_s)) && !I_WR |=> $stable(seed_q))
    else $error("sequence moved while not running");

  chk_reset_load: assert property (
    restart_s |=> seed_q == $past(shadow_q))
    else $error("reset input did not reload the start value");

  chk_seed_copy: assert property (
    seed_write_s ##1 quiet_s [*2] |=> shadow_q == $past(I_WDATA[7:0], 3))
    else $error("seed write did not reach the shadow start value");

  chk_kill_low: assert property (
    kill_s |=> !O_DENSITY_OUT_A && !O_DENSITY_OUT_B)
    else $error("density outputs not low under kill");

  chk_bit_lsb: assert property (
    run_en && en_s && !rst_s && !I_WR |=>
      O_BITSTREAM == ($past(seed_q[1]) ^ ($past(seed_q[0]) & $past(taps_q[0]))))
    else $error("bit stream is not the lsb of the stepped register");

  chk_cmp_a_out: assert property (
    run_en && !kill_s |=> O_DENSITY_OUT_A ==
      ($past(sel_a) ? ($past(seed_q) >= $past(thr_a_q))
                    : ($past(seed_q) <= $past(thr_a_q))))
    else $error("output a does not match its compare");

  chk_cmp_b_out: assert property (
    run_en && !kill_s |=> O_DENSITY_OUT_B ==
      ($past(sel_b) ? ($past(seed_q) >= $past(thr_b_q))
                    : ($past(seed_q) <= $past(thr_b_q))))
    else $error("output b does not match its compare");

  chk_stop_hold: assert property (
    !run_en && !kill_s |=> $stable(O_DENSITY_OUT_A) && $stable(O_DENSITY_OUT_B))
    else $error("outputs changed while stopped");

  chk_sync_delay: assert property (
    ##2 1'b1 |-> kill_s == $past(I_KILL, 2) && rst_s == $past(I_RESET, 2) &&
      en_s == $past(I_ENABLE, 2))
    else $error("input sync is not two stages");

  chk_read_seed: assert property (
    I_RD && I_ADDR == pdm_pkg::OFS_SEED |=> O_RDATA[7:0] == $past(seed_q))
    else $error("seed read data wrong");

  chk_read_idle: assert property (
    !I_RD |=> O_RDATA == '0)
    else $error("read data not cleared after the read cycle");

  chk_read_unmapped: assert property (
    I_RD && I_ADDR > pdm_pkg::OFS_THR_B |=> O_RDATA == '0)
    else $error("unmapped read gave nonzero data");

  chk_seed_write: assert property (
    seed_write_s |=> seed_q == $past(wval) && shadow_q == $past(wval))
    else $error("seed write did not land in both seed registers");

  chk_shadow_keep: assert property (
    quiet_s |=> $stable(shadow_q))
    else $error("start value changed without a write");

  chk_reset_wins: assert property (
    run_en && rst_s && en_s && !I_WR |=> seed_q == $past(shadow_q))
    else $error("enable beat the reset input");

  chk_taps_write: assert property (
    I_WR && I_ADDR == pdm_pkg::OFS_TAPS |=> taps_q == $past(wval))
    else $error("taps write did not land");

  chk_taps_read: assert property (
    I_RD && I_ADDR == pdm_pkg::OFS_TAPS |=> O_RDATA[pdm_pkg::LFSR_W-1:0] == $past(taps_q))
    else $error("taps read data wrong");

  chk_thr_a_write: assert property (
    I_WR && I_ADDR == pdm_pkg::OFS_THR_A |=> thr_a_q == $past(wval))
    else $error("threshold a write did not land");

  chk_thr_b_write: assert property (
    I_WR && I_ADDR == pdm_pkg::OFS_THR_B |=> thr_b_q == $past(wval))
    else $error("threshold b write did not land");

  chk_ctrl_write: assert property (
    I_WR && I_ADDR == pdm_pkg::OFS_CTRL |=> ctrl_q == $past(I_WDATA[pdm_pkg::CTRL_W-1:0]))
    else $error("control write did not land");

  chk_cfg_keep: assert property (
    quiet_s |=> $stable(taps_q) && $stable(thr_a_q) && $stable(thr_b_q))
    else $error("taps or thresholds changed without a write");

endmodule : lfsr_pulse_density_modulator

`default_nettype wire

// ===== tb/pdm_pin_source.sv
// Purpose: far-side logic that drives the enable, restart and kill pins
// Assumes: levels change just after a rising clock edge
// Notes: each level stands at least one whole clock, the shortest pulse the pins accept
`default_nettype none

module pdm_pin_source (
  input wire logic i_clk,
  input wire logic [2:0] i_want,
  output logic o_enable,
  output logic o_restart,
  output logic o_kill
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    {o_kill, o_restart, o_enable} = 3'h0;
  end

  always @(posedge i_clk) begin
    {o_kill, o_restart, o_enable} <= i_want;
  end
endmodule : pdm_pin_source

`default_nettype wire

// ===== tb/tb_lfsr_pulse_density_modulator.sv
// Purpose: self-checking bench, cycle model compared with the design every clock
// Assumes: register index equals address, 2-flop pin sync, one-cycle read latency
// Notes: random pins and bus traffic from a fixed seed
`default_nettype none

module tb_lfsr_pulse_density_modulator;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, rst_b, wr, rd, pin_en, pin_rst, pin_kill, den_a, den_b, bits;
  logic [2:0] addr, want;
  logic [31:0] wdata, rdata, d, v;
  int failures, cmp_count, m[8], s1, s2, e_a, e_b, e_rd, op;
  bit go;

  lfsr_pulse_density_modulator dut (.I_CLK(clk), .I_RST_B(rst_b), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_ENABLE(pin_en),
    .I_RESET(pin_rst), .I_KILL(pin_kill), .O_DENSITY_OUT_A(den_a),
    .O_DENSITY_OUT_B(den_b), .O_BITSTREAM(bits));

  pdm_pin_source far (.i_clk(clk), .i_want(want), .o_enable(pin_en),
    .o_restart(pin_rst), .o_kill(pin_kill));

  always #25 clk = ~clk;

  // reference model: state after each edge, from the inputs seen before it
  always @(posedge clk or negedge rst_b) begin
    // checks start at the first clock edge, once reset values are certain
    if (clk) go = 1;
    if (!rst_b) begin
      m = '{0, 1, 1, 'hb8, 'h80, 'h80, 0, 0};
      s1 = 0;
      s2 = 0;
      e_a = 0;
      e_b = 0;
      e_rd = 0;
    end else begin
      e_rd = rd ? m[addr] : 0;
      if (s2 & 4) begin
        e_a = 0;
        e_b = 0;
      end else if (m[0] & 1) begin
        e_a = (m[0] & 2) ? m[1] >= m[4] : m[1] <= m[4];
        e_b = (m[0] & 4) ? m[1] >= m[5] : m[1] <= m[5];
      end
      if (m[0] & 1) begin
        if (s2 & 2) m[1] = m[2];
        else if (s2 & 1) m[1] = (m[1] >> 1) ^ ((m[1] & 1) ? m[3] : 0);
      end
      if (wr && addr < 6) begin
        m[addr] = wdata & (addr == 0 ? 7 : 255);
        if (addr == 1) m[2] = m[1];
      end
      s2 = s1;
      s1 = {pin_kill, pin_rst, pin_en};
    end
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  always @(negedge clk) begin
    if (go) begin
      chk("rdata", rdata, e_rd);
      chk("den_a", den_a, e_a);
      chk("den_b", den_b, e_b);
      chk("bitstream", bits, m[1] & 1);
    end
  end

  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= v;
  endtask : bus

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  initial begin
    #500000;
    failures++;
    stop_test();
  end

  initial begin
    {clk, rst_b, wr, rd, addr, wdata, want} = '0;
    void'($urandom(50475));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) bus(0, 1, a[2:0], 0);
    bus(1, 0, 3'h7, 32'hffffffff);
    bus(1, 0, 3'h3, 32'hb8);
    bus(1, 0, 3'h0, 32'h1);
    want <= 3'h1;
    repeat (300) bus(0, 0, 0, 0);
    repeat (3000) begin
      op = $urandom % 8;
      d = $urandom;
      v = d;
      if (d[10:8] == 3) v = 32'hb8;
      if (d[10:8] == 1 || d[10:8] == 2) v = d % 255 + 1;
      bus(op == 4, op < 4, d[10:8], v);
      want <= {$urandom % 16 == 0, $urandom % 16 == 0, $urandom % 4 != 0};
    end
    bus(0, 0, 0, 0);
    repeat (4) @(posedge clk);
    stop_test();
  end
endmodule : tb_lfsr_pulse_density_modulator

`default_nettype wire
